// ---- sim/regs_props.sv ----
`timescale 1ns/1ps
module regs_props (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic [3:0] op,
	input wire logic [2:0] alu_op,
	input wire logic [7:0] operand,
	input wire logic load_work,
	input wire logic fetch,
	input wire logic break_req,
	input wire logic reg_wr,
	input wire logic mem_ready,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [15:0] mem_addr,
	input wire logic cpu_clk_run,
	input wire logic [7:0] work_byte,
	input wire logic [15:0] push_pull_ptr,
	input wire logic [15:0] next_fetch_ptr,
	input wire logic [7:0] flags_byte,
	input wire logic busy
);
	wire run = !busy && clk_en && !reg_wr && !load_work;
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	fixed_ones_a: assert property (flags_byte[6:5] == 2'b11)
		else $error("flags bits 6 and 5 not one");
	reset_vals_a: assert property ($rose(resetn) |-> push_pull_ptr == 16'h00ff
		&& flags_byte == cpu_regs_pkg::flags_reset) else $error("bad reset values");
	reset_vec_a: assert property ($rose(resetn) |-> mem_rd && mem_addr == 16'hfffe)
		else $error("reset vector not fetched");
	low_preset_a: assert property (run && op == cpu_regs_pkg::op_stack_low_byte_preset
		|=> push_pull_ptr == {$past(push_pull_ptr[15:8]), 8'hff}) else $error("preset wrong");
	push_dec_a: assert property (mem_wr && mem_ready && clk_en && !reg_wr
		|=> push_pull_ptr == $past(push_pull_ptr) - 16'h1) else $error("push no decrement");
	fetch_inc_a: assert property (run && op == 4'h0 && fetch && flags_byte[3] && !break_req
		|=> next_fetch_ptr == $past(next_fetch_ptr) + 16'h1) else $error("pc not advanced");
	mask_block_a: assert property (run && op == 4'h0 && flags_byte[3] && !break_req
		|=> !mem_wr) else $error("stacking while masked");
	half_add_a: assert property (run && op == cpu_regs_pkg::op_alu && alu_op == 3'h0
		|=> flags_byte[4] == (({1'b0, $past(work_byte[3:0])} + $past(operand[3:0])) > 5'd15))
		else $error("half carry wrong");
	neg_zero_a: assert property (run && op == cpu_regs_pkg::op_alu
		|=> flags_byte[2] == work_byte[7] && flags_byte[1] == (work_byte == 8'h00))
		else $error("n or z wrong");
	wait_mask_a: assert property (run && op == cpu_regs_pkg::op_wait
		|-> ##[1:3] (!flags_byte[3] && !cpu_clk_run)) else $error("wait entry wrong");
	cover property (mem_wr && mem_ready);
	cover property ($fell(cpu_clk_run));
	cover property (run && op == cpu_regs_pkg::op_alu);
endmodule
bind cpu_register_file_flags regs_props chk_i (.mclk(mclk), .resetn(resetn), .clk_en(clk_en),
	.op(op), .alu_op(alu_op), .operand(operand), .load_work(load_work), .fetch(fetch),
	.break_req(break_req), .reg_wr(reg_wr), .mem_ready(mem_ready), .mem_rd(mem_rd),
	.mem_wr(mem_wr), .mem_addr(mem_addr), .cpu_clk_run(cpu_clk_run), .work_byte(work_byte),
	.push_pull_ptr(push_pull_ptr), .next_fetch_ptr(next_fetch_ptr), .flags_byte(flags_byte),
	.busy(busy));

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	logic mclk = 0, resetn = 0, clk_en = 1, load_work = 0, load_ptr = 0, fetch = 0;
	logic break_req = 0, monitor_mode = 0, mem_ready = 1, wake_irq = 0, reg_wr = 0, reg_rd = 0;
	logic [3:0] op = 0;
	logic [2:0] alu_op = 0, reg_addr = 0;
	logic [7:0] operand = 0, reg_wdata = 0, irq_pending = 0, reg_rdata, instr_q, work_byte;
	logic [7:0] flags_byte, mem_wdata;
	logic [15:0] ptr_in = 0, jump_addr = 0, mem_addr, pointer_word, push_pull_ptr, next_fetch_ptr;
	logic mem_rd, mem_wr, cpu_clk_run, busy;
	int n_errors = 0, num_checks = 0, cyc = 0, n_wr = 0;
	logic [7:0] ram [0:255];
	function automatic logic [7:0] mf(input logic [15:0] a);
		return a[15:8] ^ a[7:0] ^ 8'h5a;
	endfunction
	wire [7:0] mem_rdata = mf(mem_addr);
	cpu_register_file_flags #(.n_irq(8), .settle_cycles(8)) uut (.mclk(mclk), .resetn(resetn),
		.clk_en(clk_en), .op(op), .alu_op(alu_op), .operand(operand), .load_work(load_work),
		.load_ptr(load_ptr), .ptr_in(ptr_in), .fetch(fetch), .jump_addr(jump_addr),
		.pull_data(8'h00), .irq_pending(irq_pending), .break_req(break_req),
		.monitor_mode(monitor_mode), .mem_ready(mem_ready), .mem_rdata(mem_rdata),
		.wake_irq(wake_irq), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_addr(mem_addr), .mem_rd(mem_rd),
		.mem_wr(mem_wr), .mem_wdata(mem_wdata), .instr_q(instr_q), .cpu_clk_run(cpu_clk_run),
		.work_byte(work_byte), .pointer_word(pointer_word), .push_pull_ptr(push_pull_ptr),
		.next_fetch_ptr(next_fetch_ptr), .flags_byte(flags_byte), .busy(busy));
	always #12.5 mclk = ~mclk;
	task automatic report_and_stop;
		if (n_errors == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	always @(posedge mclk) begin
		mem_ready <= ($urandom % 3) != 0;
		cyc <= cyc + 1;
		if (mem_wr && mem_ready) begin
			n_wr <= n_wr + 1;
			ram[mem_addr[7:0]] <= mem_wdata;
		end
		if (cyc == 20000) begin
			n_errors = n_errors + 1;
			report_and_stop;
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic idle;
		int i;
		i = 0;
		#1;
		while (busy !== 1'b0 && i < 500) begin
			@(posedge mclk);
			#1;
			i++;
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge mclk) reg_wr <= 0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge mclk) {reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge mclk) reg_rd <= 0;
		#1 chk(reg_rdata, e);
	endtask
	task automatic doop(input logic [3:0] o, input logic [2:0] k, input logic [7:0] b);
		@(posedge mclk) {op, alu_op, operand} <= {o, k, b};
		@(posedge mclk) op <= 0;
		idle;
	endtask
	task automatic sleep(input logic [3:0] o);
		@(posedge mclk) op <= o;
		@(posedge mclk) op <= 0;
		repeat (3) @(posedge mclk);
		#1 chk({flags_byte[3], cpu_clk_run}, 2'b00);
		@(posedge mclk) wake_irq <= 1;
		@(posedge mclk) wake_irq <= 0;
	endtask
	function automatic logic [10:0] ex(input logic [2:0] k, input logic [7:0] a, b, input logic c);
		logic [8:0] s;
		logic h, v;
		h = ({1'b0, a[3:0]} + b[3:0] + (k[0] & c)) > 5'd15;
		case (k)
			3'h0, 3'h1: s = a + b + (k[0] & c);
			3'h2: s = {1'b0, a} - b;
			3'h3: s = {c, a & b};
			3'h4: s = {c, a | b};
			3'h5: s = {c, a ^ b};
			3'h6: s = {a, 1'b0};
			default: s = {a[0], 1'b0, a[7:1]};
		endcase
		v = (k == 3'h2) ? (a[7] != b[7] && s[7] != a[7]) : (a[7] == b[7] && s[7] != a[7]);
		return {v, h, s};
	endfunction
	initial begin
		logic [7:0] a, b;
		logic [7:0] sw, sf;
		logic [10:0] e;
		logic [15:0] p, j;
		logic c;
		int w, n;
		void'($urandom(32'h0f8d));
		repeat (3) @(posedge mclk);
		resetn <= 1;
		idle;
		chk(next_fetch_ptr, {mf(16'hfffe), mf(16'hffff)});
		rd(cpu_regs_pkg::ra_sp_hi, 8'h00);
		rd(cpu_regs_pkg::ra_sp_lo, 8'hff);
		rd(cpu_regs_pkg::ra_flags, 8'h68);
		wr(cpu_regs_pkg::ra_flags, 8'h9f);
		rd(cpu_regs_pkg::ra_flags, 8'hff);
		for (int r = 0; r < 7; r++) begin
			b = 8'($urandom);
			wr(3'(r), b);
			rd(3'(r), b);
		end
		p = $urandom;
		@(posedge mclk) {load_ptr, ptr_in} <= {1'b1, p};
		@(posedge mclk) load_ptr <= 0;
		rd(cpu_regs_pkg::ra_ptr_hi, p[15:8]);
		rd(cpu_regs_pkg::ra_ptr_lo, p[7:0]);
		wr(cpu_regs_pkg::ra_flags, 8'h68);
		c = 0;
		for (int i = 0; i < 40; i++) begin
			a = (i == 0) ? 8'hff : (i == 2) ? 8'h80 : 8'($urandom);
			b = (i == 0 || i == 2) ? 8'h01 : 8'($urandom);
			@(posedge mclk) {load_work, operand} <= {1'b1, a};
			@(posedge mclk) load_work <= 0;
			doop(cpu_regs_pkg::op_alu, 3'(i % 8), b);
			e = ex(3'(i % 8), a, b, c);
			chk(work_byte, e[7:0]);
			chk(flags_byte[2:1], {e[7], e[7:0] == 8'h00});
			if (i % 8 < 3 || i % 8 > 5) chk(flags_byte[0], e[8]);
			if (i % 8 < 2) chk(flags_byte[4], e[9]);
			if (i % 8 < 3) chk(flags_byte[7], e[10]);
			if (i % 8 < 3 || i % 8 > 5) c = e[8];
		end
		wr(cpu_regs_pkg::ra_sp_hi, 8'h12);
		wr(cpu_regs_pkg::ra_sp_lo, 8'h34);
		doop(cpu_regs_pkg::op_stack_low_byte_preset, 3'h0, 8'h00);
		chk(push_pull_ptr, 16'h12ff);
		doop(cpu_regs_pkg::op_push, 3'h0, 8'h00);
		chk(push_pull_ptr, 16'h12fe);
		doop(cpu_regs_pkg::op_pull, 3'h0, 8'h00);
		chk(push_pull_ptr, 16'h12ff);
		@(posedge mclk) {clk_en, op} <= {1'b0, 4'(cpu_regs_pkg::op_push)};
		repeat (3) @(posedge mclk);
		{clk_en, op} <= {1'b1, 4'h0};
		#1 chk(push_pull_ptr, 16'h12ff);
		j = $urandom;
		@(posedge mclk) jump_addr <= j;
		doop(cpu_regs_pkg::op_jump, 3'h0, 8'h00);
		chk(next_fetch_ptr, j);
		@(posedge mclk) fetch <= 1;
		@(posedge mclk) fetch <= 0;
		#1 chk(next_fetch_ptr, j + 16'h1);
		wr(cpu_regs_pkg::ra_sp_hi, 8'h00);
		wr(cpu_regs_pkg::ra_sp_lo, 8'h80);
		sw = work_byte;
		sf = flags_byte & 8'hf7;
		w = n_wr;
		@(posedge mclk) irq_pending <= 8'h06;
		repeat (6) @(posedge mclk);
		#1 chk(16'(n_wr - w), 16'h0);
		doop(cpu_regs_pkg::op_unmask, 3'h0, 8'h00);
		for (n = 0; n < 20 && mem_wr !== 1'b1; n++) begin
			@(posedge mclk);
			#1;
		end
		#1 chk(flags_byte[3], 1'b0);
		idle;
		@(posedge mclk) irq_pending <= 0;
		chk(16'(n_wr - w), 16'h5);
		chk({flags_byte[3], push_pull_ptr}, {1'b1, 16'h007b});
		chk(next_fetch_ptr, {mf(16'hffee), mf(16'hffef)});
		chk({ram[8'h7f], ram[8'h80]}, j + 16'h1);
		chk({ram[8'h7d], ram[8'h7c]}, {sw, sf});
		chk(ram[8'h7e], p[7:0]);
		doop(cpu_regs_pkg::op_return_from_irq, 3'h0, 8'h00);
		chk({flags_byte, work_byte}, {mf(16'h7c) | 8'h60, mf(16'h7d)});
		chk(pointer_word, {p[15:8], mf(16'h7e)});
		chk(next_fetch_ptr, {mf(16'h7f), mf(16'h80)});
		doop(cpu_regs_pkg::op_set_mask, 3'h0, 8'h00);
		sleep(cpu_regs_pkg::op_wait);
		idle;
		chk({flags_byte[3], cpu_clk_run}, 2'b01);
		doop(cpu_regs_pkg::op_set_mask, 3'h0, 8'h00);
		sleep(cpu_regs_pkg::op_stop);
		for (n = 0; n < 40 && cpu_clk_run !== 1'b1; n++) begin
			@(posedge mclk);
			#1;
		end
		chk(n >= 8 && n <= 12 && !flags_byte[3], 1'b1);
		for (int m = 0; m < 2; m++) begin
			@(posedge mclk) {monitor_mode, break_req} <= {m[0], 1'b1};
			for (n = 0; n < 20 && busy !== 1'b1; n++) begin
				@(posedge mclk);
				#1;
			end
			@(posedge mclk) break_req <= 0;
			idle;
			chk(instr_q, cpu_regs_pkg::software_trap_code);
			p = m ? 16'hfefc : 16'hfffc;
			chk(next_fetch_ptr, {mf(p), mf(p + 16'h1)});
		end
		@(posedge mclk) op <= cpu_regs_pkg::op_wait;
		@(posedge mclk) op <= 0;
		@(posedge mclk) resetn <= 0;
		repeat (3) @(posedge mclk);
		resetn <= 1;
		idle;
		chk(flags_byte, cpu_regs_pkg::flags_reset);
		report_and_stop;
	end
endmodule

// ---- src/cpu_register_file_flags.sv ----
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module cpu_register_file_flags #(
	parameter int n_irq = 8,
	parameter int settle_cycles = cpu_regs_pkg::osc_settle_cycles
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic [3:0] op,
	input wire logic [2:0] alu_op,
	input wire logic [7:0] operand,
	input wire logic load_work,
	input wire logic load_ptr,
	input wire logic [15:0] ptr_in,
	input wire logic fetch,
	input wire logic [15:0] jump_addr,
	input wire logic [7:0] pull_data,
	input wire logic [n_irq-1:0] irq_pending,
	input wire logic break_req,
	input wire logic monitor_mode,
	input wire logic mem_ready,
	input wire logic [7:0] mem_rdata,
	input wire logic wake_irq,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic [15:0] mem_addr,
	output logic mem_rd,
	output logic mem_wr,
	output logic [7:0] mem_wdata,
	output logic [7:0] instr_q,
	output logic cpu_clk_run,
	output logic [7:0] work_byte,
	output logic [15:0] pointer_word,
	output logic [15:0] push_pull_ptr,
	output logic [15:0] next_fetch_ptr,
	output logic [7:0] flags_byte,
	output logic busy
);
	typedef enum logic [3:0] {
		st_vec_hi, st_vec_lo, st_run, st_stack, st_mask, st_unstack, st_wait, st_stop, st_settle
	} state_t;
	state_t state_q;
	logic [7:0] work_q;
	logic [15:0] ptr_q;
	logic [15:0] sp_q;
	logic [15:0] pc_q;
	logic [7:0] flags_q;
	logic [2:0] step_q;
	logic [15:0] vec_q;
	logic [15:0] settle_q;
	logic [7:0] alu_res;
	logic alu_c;
	logic alu_h;
	logic alu_v;
	logic c_ok;
	logic h_ok;
	logic v_ok;
	logic irq_take;
	logic [2:0] irq_idx;
	logic running;
	logic start_irq;
	logic start_brk;
	logic [7:0] stack_byte;

	flag_alu u_alu (
		.alu_op(alu_op),
		.opa(work_q),
		.opb(operand),
		.cin(flags_q[cpu_regs_pkg::flag_c]),
		.result(alu_res),
		.carry(alu_c),
		.half(alu_h),
		.ovf(alu_v),
		.carry_valid(c_ok),
		.half_valid(h_ok),
		.ovf_valid(v_ok)
	);

	irq_priority #(.n_irq(n_irq)) u_prio (
		.pending(irq_pending),
		.mask(flags_q[cpu_regs_pkg::flag_i]),
		.take(irq_take),
		.index(irq_idx)
	);

	function automatic logic [15:0] stack_step(input logic [15:0] sp, input logic down);
		stack_step = down ? sp - 16'h0001 : sp + 16'h0001;
	endfunction

	assign running = (state_q == st_run);
	assign start_brk = running && break_req;
	assign start_irq = running && !break_req && irq_take;
	assign busy = !running;

	always_comb begin
		case (step_q)
			3'h0: stack_byte = pc_q[7:0];
			3'h1: stack_byte = pc_q[15:8];
			3'h2: stack_byte = ptr_q[7:0];
			3'h3: stack_byte = work_q;
			default: stack_byte = flags_q;
		endcase
	end

	always_comb begin
		mem_addr = sp_q;
		mem_rd = 1'b0;
		mem_wr = 1'b0;
		mem_wdata = stack_byte;
		case (state_q)
			st_vec_hi: begin
				mem_addr = vec_q;
				mem_rd = 1'b1;
			end
			st_vec_lo: begin
				mem_addr = vec_q + 16'h0001;
				mem_rd = 1'b1;
			end
			st_stack: mem_wr = 1'b1;
			st_unstack: begin
				mem_addr = sp_q + 16'h0001;
				mem_rd = 1'b1;
			end
			default: begin
				mem_addr = pc_q;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_q <= st_vec_hi;
			step_q <= 3'h0;
			vec_q <= cpu_regs_pkg::vec_reset;
			settle_q <= 16'h0000;
		end else if (clk_en) begin
			case (state_q)
				st_vec_hi: if (mem_ready) state_q <= st_vec_lo;
				st_vec_lo: if (mem_ready) state_q <= st_run;
				st_run: begin
					step_q <= 3'h0;
					if (start_brk) begin
						vec_q <= monitor_mode ? cpu_regs_pkg::vec_trap_mon : cpu_regs_pkg::vec_trap;
						state_q <= st_stack;
					end else if (start_irq) begin
						vec_q <= cpu_regs_pkg::vec_irq_base - {12'h000, irq_idx, 1'b0};
						state_q <= st_stack;
					end else if (op == 4'(cpu_regs_pkg::op_return_from_irq)) begin
						state_q <= st_unstack;
					end else if (op == 4'(cpu_regs_pkg::op_wait)) begin
						state_q <= st_wait;
					end else if (op == 4'(cpu_regs_pkg::op_stop)) begin
						state_q <= st_stop;
					end
				end
				st_stack: if (mem_ready) begin
					step_q <= step_q + 3'h1;
					if (step_q == 3'h4) state_q <= st_mask;
				end
				st_mask: state_q <= st_vec_hi;
				st_unstack: if (mem_ready) begin
					step_q <= step_q + 3'h1;
					if (step_q == 3'h4) state_q <= st_run;
				end
				st_wait: if (wake_irq) state_q <= st_run;
				st_stop: if (wake_irq) begin
					settle_q <= 16'(settle_cycles);
					state_q <= st_settle;
				end
				st_settle: begin
					settle_q <= settle_q - 16'h0001;
					if (settle_q <= 16'h0001) state_q <= st_run;
				end
				default: state_q <= st_run;
			endcase
		end
	end

	assign cpu_clk_run = !(state_q == st_wait || state_q == st_stop || state_q == st_settle);

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			instr_q <= 8'h00;
		end else if (clk_en && start_brk) begin
			instr_q <= cpu_regs_pkg::software_trap_code;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			work_q <= 8'h00;
		end else if (clk_en) begin
			if (reg_wr && reg_addr == cpu_regs_pkg::ra_work) begin
				work_q <= reg_wdata;
			end else if (state_q == st_unstack && mem_ready && step_q == 3'h1) begin
				work_q <= mem_rdata;
			end else if (running && op == 4'(cpu_regs_pkg::op_alu)) begin
				work_q <= alu_res;
			end else if (running && load_work) begin
				work_q <= operand;
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ptr_q <= 16'h0000;
		end else if (clk_en) begin
			if (reg_wr && reg_addr == cpu_regs_pkg::ra_ptr_hi) begin
				ptr_q[15:8] <= reg_wdata;
			end else if (reg_wr && reg_addr == cpu_regs_pkg::ra_ptr_lo) begin
				ptr_q[7:0] <= reg_wdata;
			end else if (state_q == st_unstack && mem_ready && step_q == 3'h2) begin
				ptr_q[7:0] <= mem_rdata;
			end else if (running && load_ptr) begin
				ptr_q <= ptr_in;
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			sp_q <= cpu_regs_pkg::sp_reset;
		end else if (clk_en) begin
			if (reg_wr && reg_addr == cpu_regs_pkg::ra_sp_hi) begin
				sp_q[15:8] <= reg_wdata;
			end else if (reg_wr && reg_addr == cpu_regs_pkg::ra_sp_lo) begin
				sp_q[7:0] <= reg_wdata;
			end else if ((state_q == st_stack || state_q == st_unstack) && mem_ready) begin
				sp_q <= stack_step(sp_q, state_q == st_stack);
			end else if (running && !start_brk && !start_irq) begin
				case (op)
					4'(cpu_regs_pkg::op_stack_low_byte_preset): sp_q[7:0] <= cpu_regs_pkg::sp_low_preset;
					4'(cpu_regs_pkg::op_push): sp_q <= stack_step(sp_q, 1'b1);
					4'(cpu_regs_pkg::op_pull): sp_q <= stack_step(sp_q, 1'b0);
					default: sp_q <= sp_q;
				endcase
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			pc_q <= 16'h0000;
		end else if (clk_en) begin
			if (reg_wr && reg_addr == cpu_regs_pkg::ra_pc_hi) begin
				pc_q[15:8] <= reg_wdata;
			end else if (reg_wr && reg_addr == cpu_regs_pkg::ra_pc_lo) begin
				pc_q[7:0] <= reg_wdata;
			end else if (state_q == st_vec_hi && mem_ready) begin
				pc_q[15:8] <= mem_rdata;
			end else if (state_q == st_vec_lo && mem_ready) begin
				pc_q[7:0] <= mem_rdata;
			end else if (state_q == st_unstack && mem_ready && step_q == 3'h3) begin
				pc_q[15:8] <= mem_rdata;
			end else if (state_q == st_unstack && mem_ready && step_q == 3'h4) begin
				pc_q[7:0] <= mem_rdata;
			end else if (running && !start_brk && !start_irq) begin
				if (op == 4'(cpu_regs_pkg::op_jump)) begin
					pc_q <= jump_addr;
				end else if (fetch) begin
					pc_q <= pc_q + 16'h0001;
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			flags_q <= cpu_regs_pkg::flags_reset;
		end else if (clk_en) begin
			if (reg_wr && reg_addr == cpu_regs_pkg::ra_flags) begin
				flags_q <= reg_wdata | cpu_regs_pkg::flags_fixed_ones;
			end else if (state_q == st_mask) begin
				flags_q[cpu_regs_pkg::flag_i] <= 1'b1;
			end else if (state_q == st_unstack && mem_ready && step_q == 3'h0) begin
				flags_q <= mem_rdata | cpu_regs_pkg::flags_fixed_ones;
			end else if (running && !start_brk && !start_irq) begin
				case (op)
					4'(cpu_regs_pkg::op_alu): begin
						flags_q[cpu_regs_pkg::flag_n] <= alu_res[7];
						flags_q[cpu_regs_pkg::flag_z] <= (alu_res == 8'h00);
						if (c_ok) flags_q[cpu_regs_pkg::flag_c] <= alu_c;
						if (h_ok) flags_q[cpu_regs_pkg::flag_h] <= alu_h;
						if (v_ok) flags_q[cpu_regs_pkg::flag_v] <= alu_v;
					end
					4'(cpu_regs_pkg::op_unmask): flags_q[cpu_regs_pkg::flag_i] <= 1'b0;
					4'(cpu_regs_pkg::op_set_mask): flags_q[cpu_regs_pkg::flag_i] <= 1'b1;
					4'(cpu_regs_pkg::op_wait): flags_q[cpu_regs_pkg::flag_i] <= 1'b0;
					4'(cpu_regs_pkg::op_stop): flags_q[cpu_regs_pkg::flag_i] <= 1'b0;
					default: flags_q <= flags_q;
				endcase
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 8'h00;
		end else if (clk_en) begin
			if (reg_rd) begin
				case (reg_addr)
					cpu_regs_pkg::ra_work: reg_rdata <= work_q;
					cpu_regs_pkg::ra_ptr_hi: reg_rdata <= ptr_q[15:8];
					cpu_regs_pkg::ra_ptr_lo: reg_rdata <= ptr_q[7:0];
					cpu_regs_pkg::ra_sp_hi: reg_rdata <= sp_q[15:8];
					cpu_regs_pkg::ra_sp_lo: reg_rdata <= sp_q[7:0];
					cpu_regs_pkg::ra_pc_hi: reg_rdata <= pc_q[15:8];
					cpu_regs_pkg::ra_pc_lo: reg_rdata <= pc_q[7:0];
					default: reg_rdata <= flags_q | cpu_regs_pkg::flags_fixed_ones;
				endcase
			end else begin
				reg_rdata <= 8'h00;
			end
		end
	end

	assign work_byte = work_q;
	assign pointer_word = ptr_q;
	assign push_pull_ptr = sp_q;
	assign next_fetch_ptr = pc_q;
	assign flags_byte = flags_q | cpu_regs_pkg::flags_fixed_ones;
endmodule

// ---- src/cpu_regs_pkg.sv ----
package cpu_regs_pkg;
	localparam logic [15:0] sp_reset = 16'h00ff;
	localparam logic [7:0] sp_low_preset = 8'hff;
	localparam logic [15:0] vec_reset = 16'hfffe;
	localparam logic [15:0] vec_trap = 16'hfffc;
	localparam logic [15:0] vec_trap_mon = 16'hfefc;
	localparam logic [15:0] vec_irq_base = 16'hfff0;
	localparam logic [7:0] software_trap_code = 8'h83;
	localparam logic [7:0] flags_reset = 8'h68;
	localparam int flag_c = 0;
	localparam int flag_z = 1;
	localparam int flag_n = 2;
	localparam int flag_i = 3;
	localparam int flag_h = 4;
	localparam int flag_v = 7;
	localparam logic [7:0] flags_fixed_ones = 8'h60;
	localparam int osc_settle_ns = 4000;
	localparam int clk_period_ns = 25;
	localparam int osc_settle_cycles = (osc_settle_ns + clk_period_ns - 1) / clk_period_ns;
	localparam logic [2:0] ra_work = 3'h0;
	localparam logic [2:0] ra_ptr_hi = 3'h1;
	localparam logic [2:0] ra_ptr_lo = 3'h2;
	localparam logic [2:0] ra_sp_hi = 3'h3;
	localparam logic [2:0] ra_sp_lo = 3'h4;
	localparam logic [2:0] ra_pc_hi = 3'h5;
	localparam logic [2:0] ra_pc_lo = 3'h6;
	localparam logic [2:0] ra_flags = 3'h7;
	typedef enum logic [3:0] {
		op_none, op_alu, op_push, op_pull, op_stack_low_byte_preset, op_jump,
		op_return_from_irq, op_unmask, op_set_mask, op_wait, op_stop
	} op_t;
	typedef enum logic [2:0] {
		alu_add, alu_adc, alu_sub, alu_and, alu_or, alu_xor, alu_shl, alu_shr
	} alu_op_t;
endpackage

// ---- src/flag_alu.sv ----
`timescale 1ns/1ps
module flag_alu (
	input wire logic [2:0] alu_op,
	input wire logic [7:0] opa,
	input wire logic [7:0] opb,
	input wire logic cin,
	output logic [7:0] result,
	output logic carry,
	output logic half,
	output logic ovf,
	output logic carry_valid,
	output logic half_valid,
	output logic ovf_valid
);
	logic [8:0] sum;
	logic [4:0] nib;
	logic c_in;
	always_comb begin
		c_in = (alu_op == 3'(cpu_regs_pkg::alu_adc)) ? cin : 1'b0;
		sum = {1'b0, opa} + {1'b0, opb} + {8'h00, c_in};
		nib = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, c_in};
		result = 8'h00;
		carry = 1'b0;
		half = 1'b0;
		ovf = 1'b0;
		carry_valid = 1'b0;
		half_valid = 1'b0;
		ovf_valid = 1'b1;
		case (alu_op)
			3'(cpu_regs_pkg::alu_add), 3'(cpu_regs_pkg::alu_adc): begin
				result = sum[7:0];
				carry = sum[8];
				half = nib[4];
				ovf = (opa[7] == opb[7]) && (sum[7] != opa[7]);
				carry_valid = 1'b1;
				half_valid = 1'b1;
			end
			3'(cpu_regs_pkg::alu_sub): begin
				result = opa - opb;
				carry = opb > opa;
				ovf = (opa[7] != opb[7]) && (result[7] != opa[7]);
				carry_valid = 1'b1;
			end
			3'(cpu_regs_pkg::alu_and): result = opa & opb;
			3'(cpu_regs_pkg::alu_or): result = opa | opb;
			3'(cpu_regs_pkg::alu_xor): result = opa ^ opb;
			3'(cpu_regs_pkg::alu_shl): begin
				result = {opa[6:0], 1'b0};
				carry = opa[7];
				ovf = opa[7] ^ opa[6];
				carry_valid = 1'b1;
			end
			default: begin
				result = {1'b0, opa[7:1]};
				carry = opa[0];
				ovf = opa[0];
				carry_valid = 1'b1;
			end
		endcase
	end
endmodule

// ---- src/irq_priority.sv ----
`timescale 1ns/1ps
module irq_priority #(
	parameter int n_irq = 8
) (
	input wire logic [n_irq-1:0] pending,
	input wire logic mask,
	output logic take,
	output logic [2:0] index
);
	always_comb begin
		index = 3'h0;
		for (int k = n_irq - 1; k >= 0; k--) begin
			if (pending[k]) begin
				index = 3'(k);
			end
		end
	end
	assign take = (|pending) && !mask;
endmodule
